// file: rtl/sidr_regs.vh
`ifndef SIDR_REGS_VH
`define SIDR_REGS_VH

// ****************************************
// Peripheral and register addresses
// ****************************************
`define SIDR_ADDR_DIV_RATIO   8'h41
`define SIDR_DIV_RATIO_RESET  16'h0100

// ****************************************
// Division ratio field layout
// ****************************************
`define SIDR_PROG_MSB         15
`define SIDR_PROG_LSB         4
`define SIDR_SWAL_MSB         3
`define SIDR_SWAL_LSB         0

// ****************************************
// Mode select encodings
// ****************************************
`define SIDR_MODE_MED_DIRECT  2'h0
`define SIDR_MODE_HIGH_SWAL   2'h1
`define SIDR_MODE_VHIGH_SWAL  2'h2
`define SIDR_MODE_IN_DISABLE  2'h3
`define SIDR_MODE_RESET       2'h0

// ****************************************
// Prescaler moduli
// ****************************************
`define SIDR_PRESC_LOW_LAST   5'h0F
`define SIDR_PRESC_HIGH_LAST  5'h10

// ****************************************
// Reference select codes and divisors of the 4.5 MHz crystal
// ****************************************
`define SIDR_XTAL_HZ          4500000
`define SIDR_REF_SEL_RESET    4'hF
`define SIDR_REF_SEL_DISABLE  4'hF
`define SIDR_REF_DIV_1K25     13'hE10
`define SIDR_REF_DIV_2K5      13'h708
`define SIDR_REF_DIV_5K       13'h384
`define SIDR_REF_DIV_10K      13'h1C2
`define SIDR_REF_DIV_6K25     13'h2D0
`define SIDR_REF_DIV_12K5     13'h168
`define SIDR_REF_DIV_25K      13'h0B4
`define SIDR_REF_DIV_50K      13'h05A
`define SIDR_REF_DIV_3K       13'h5DC
`define SIDR_REF_DIV_1K       13'h1194
`define SIDR_REF_DIV_9K       13'h1F4
`define SIDR_REF_DIV_100K     13'h02D
`define SIDR_REF_DIV_NONE     13'h0000

`endif

// file: rtl/sidr_top.v
`timescale 1ns/1ps
// Overview of operation
// R1 - At most one oscillator input feeds the divider, picked by the mode select; none in input-disable.
// R2 - The oscillator input not in use has its pull-down asserted.
// R3 - Divider is a 16/17 prescaler, 4-bit swallow, 12-bit programmable counter, mode switch.
// R4 - Medium-band direct: low-band input, high-band pulled down, programmable counter only.
// R5 - High-band swallow: low-band input, high-band pulled down, both counters used.
// R6 - Very-high-band swallow: high-band input, low-band pulled down, both counters used.
// R7 - Input-disable pulls both inputs down; reference generator keeps running.
// R8 - Direct ratio is 16 to 4095; software writes 010x to FFFx, low nibble ignored.
// R9 - Swallow modes use all 16 bits; ratio 256 to 65535.
// R10 - Direct mode loads upper twelve bits to programmable counter, ignores the rest.
// R11 - Swallow mode loads upper twelve bits to programmable, low four to swallow.
// R12 - Swallow and programmable counters both count down in binary.
// R13 - Division register at address 41H is written and read back via staging buffer.
// R14 - Divided output equals input frequency divided by N (12 or 16 bits).
// R15 - Reference is derived by dividing the 4.5 MHz crystal clock.
// R16 - Twelve selectable references from 1 kHz to 100 kHz.
// R17 - Code 0000 is 1.25 kHz, 1000 is 3 kHz, 1001-1011 prohibited, 1111 disables.
// R18 - Disable code pulls both inputs down and floats the error outputs.
// R19 - Prescaler divides by 17 for swallow-count cycles, else by 16.
`include "sidr_regs.vh"

module sidr_top (
	input  wire        clk_sys_i,
	input  wire        resetn_i,
	input  wire [7:0]  periph_addr_i,
	input  wire [15:0] staging_buffer_i,
	input  wire        periph_put_i,
	input  wire        periph_get_i,
	output wire [15:0] staging_buffer_o,
	input  wire [1:0]  mode_select_i,
	input  wire [3:0]  ref_select_i,
	input  wire        high_band_osc_input_i,
	input  wire        low_band_osc_input_i,
	input  wire        xtal_clk_i,
	output wire        high_band_pulldown_o,
	output wire        low_band_pulldown_o,
	output wire        divided_frequency_o,
	output wire        reference_frequency_o,
	output wire        synth_disabled_o,
	output wire        error_out_float_o
);

	// ****************************************
	// Helper functions
	// ****************************************

	// Crystal divisor for a reference select code
	function [12:0] ref_divisor;
		input [3:0] code;
		begin
			case (code)
				4'h0: ref_divisor = `SIDR_REF_DIV_1K25;
				4'h1: ref_divisor = `SIDR_REF_DIV_2K5;
				4'h2: ref_divisor = `SIDR_REF_DIV_5K;
				4'h3: ref_divisor = `SIDR_REF_DIV_10K;
				4'h4: ref_divisor = `SIDR_REF_DIV_6K25;
				4'h5: ref_divisor = `SIDR_REF_DIV_12K5;
				4'h6: ref_divisor = `SIDR_REF_DIV_25K;
				4'h7: ref_divisor = `SIDR_REF_DIV_50K;
				4'h8: ref_divisor = `SIDR_REF_DIV_3K;
				4'hC: ref_divisor = `SIDR_REF_DIV_1K;
				4'hD: ref_divisor = `SIDR_REF_DIV_9K;
				4'hE: ref_divisor = `SIDR_REF_DIV_100K;
				default: ref_divisor = `SIDR_REF_DIV_NONE;
			endcase
		end
	endfunction

	// Rising edge seen once stages two and three agree on a new level
	function rise_ok;
		input s2;
		input s3;
		input lvl;
		begin
			rise_ok = (s2 == s3) && s3 && !lvl;
		end
	endfunction

	// ****************************************
	// Division ratio register
	// ****************************************
	reg [15:0] div_ratio_q;
	reg [15:0] rdata_q;
	wire       sel_ratio = (periph_addr_i == `SIDR_ADDR_DIV_RATIO);

	// Write from and read back into the staging buffer
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_ratio_q <= `SIDR_DIV_RATIO_RESET;
			rdata_q     <= 16'h0000;
		end else begin
			if (periph_put_i && sel_ratio) begin
				div_ratio_q <= staging_buffer_i; // see R13
			end
			if (periph_get_i && sel_ratio) begin
				rdata_q <= div_ratio_q; // see R13
			end
		end
	end
	assign staging_buffer_o = rdata_q;

	// ****************************************
	// Mode decode and input select
	// ****************************************
	wire synth_off  = (ref_select_i == `SIDR_REF_SEL_DISABLE);
	wire mode_dir   = (mode_select_i == `SIDR_MODE_MED_DIRECT);
	wire mode_hsw   = (mode_select_i == `SIDR_MODE_HIGH_SWAL);
	wire mode_vsw   = (mode_select_i == `SIDR_MODE_VHIGH_SWAL);
	wire swallow_on = mode_hsw | mode_vsw;
	wire div_run    = !synth_off && (mode_dir | swallow_on);
	wire use_high   = mode_vsw && !synth_off; // see R1 R6
	wire use_low    = (mode_dir | mode_hsw) && !synth_off; // see R1 R4 R5

	// Unused pin pulled down; both when disabled
	assign high_band_pulldown_o = !use_high; // see R2 R4 R5 R7 R18
	assign low_band_pulldown_o  = !use_low; // see R2 R6 R7 R18
	assign synth_disabled_o     = synth_off;
	assign error_out_float_o    = synth_off; // see R18

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [2:0] hb_sync_q;
	reg [2:0] lb_sync_q;
	reg [2:0] xt_sync_q;
	reg       hb_lvl_q;
	reg       lb_lvl_q;
	reg       xt_lvl_q;

	// Three-stage capture with agreed level tracking
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hb_sync_q <= 3'h0;
			lb_sync_q <= 3'h0;
			xt_sync_q <= 3'h0;
			hb_lvl_q  <= 1'b0;
			lb_lvl_q  <= 1'b0;
			xt_lvl_q  <= 1'b0;
		end else begin
			hb_sync_q <= {hb_sync_q[1:0], high_band_osc_input_i};
			lb_sync_q <= {lb_sync_q[1:0], low_band_osc_input_i};
			xt_sync_q <= {xt_sync_q[1:0], xtal_clk_i};
			if (hb_sync_q[1] == hb_sync_q[2]) begin
				hb_lvl_q <= hb_sync_q[2];
			end
			if (lb_sync_q[1] == lb_sync_q[2]) begin
				lb_lvl_q <= lb_sync_q[2];
			end
			if (xt_sync_q[1] == xt_sync_q[2]) begin
				xt_lvl_q <= xt_sync_q[2];
			end
		end
	end

	wire hb_rise = rise_ok(hb_sync_q[1], hb_sync_q[2], hb_lvl_q);
	wire lb_rise = rise_ok(lb_sync_q[1], lb_sync_q[2], lb_lvl_q);
	wire xt_rise = rise_ok(xt_sync_q[1], xt_sync_q[2], xt_lvl_q);
	wire in_edge = (use_high & hb_rise) | (use_low & lb_rise); // see R1

	// ****************************************
	// Programmable divider
	// ****************************************
	reg  [4:0]  presc_q;
	reg  [3:0]  swal_q;
	reg  [11:0] prog_q;
	reg         div_pulse_q;
	wire [11:0] prog_load = div_ratio_q[`SIDR_PROG_MSB:`SIDR_PROG_LSB]; // see R10 R11 R8
	wire [3:0]  swal_load = div_ratio_q[`SIDR_SWAL_MSB:`SIDR_SWAL_LSB]; // see R11 R9
	wire [4:0]  presc_last = (swal_q != 4'h0) ? `SIDR_PRESC_HIGH_LAST : `SIDR_PRESC_LOW_LAST; // see R19 R3
	wire        presc_wrap = swallow_on ? (presc_q == presc_last) : 1'b1;
	wire        prog_end   = (prog_q <= 12'h001);

	// Up-counting prescaler, down counters, reload and output pulse every N input cycles
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			presc_q     <= 5'h00;
			swal_q      <= 4'h0;
			prog_q      <= 12'h000;
			div_pulse_q <= 1'b0;
		end else if (!div_run) begin
			presc_q     <= 5'h00;
			swal_q      <= 4'h0;
			prog_q      <= 12'h000;
			div_pulse_q <= 1'b0;
		end else begin
			div_pulse_q <= 1'b0;
			if (in_edge) begin
				if (!presc_wrap) begin
					presc_q <= presc_q + 5'h01;
				end else begin
					presc_q <= 5'h00;
					if (prog_end) begin
						prog_q      <= prog_load; // see R10 R11 R14
						swal_q      <= swallow_on ? swal_load : 4'h0; // see R10 R11
						div_pulse_q <= 1'b1; // see R14
					end else begin
						prog_q <= prog_q - 12'h001; // see R12
						if (swal_q != 4'h0) begin
							swal_q <= swal_q - 4'h1; // see R12 R19
						end
					end
				end
			end
		end
	end
	assign divided_frequency_o = div_pulse_q;

	// ****************************************
	// Reference generator
	// ****************************************
	reg  [12:0] ref_cnt_q;
	reg         ref_pulse_q;
	wire [12:0] ref_div = ref_divisor(ref_select_i); // see R16 R17

	// Count crystal edges down from the selected divisor
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_cnt_q   <= 13'h0000;
			ref_pulse_q <= 1'b0;
		end else if (ref_div == `SIDR_REF_DIV_NONE) begin
			ref_cnt_q   <= 13'h0000; // see R17
			ref_pulse_q <= 1'b0;
		end else begin
			ref_pulse_q <= 1'b0;
			if (xt_rise) begin
				if (ref_cnt_q <= 13'h0001) begin
					ref_cnt_q   <= ref_div; // see R15
					ref_pulse_q <= 1'b1; // see R7
				end else begin
					ref_cnt_q <= ref_cnt_q - 13'h0001;
				end
			end
		end
	end
	assign reference_frequency_o = ref_pulse_q;

endmodule // sidr_top

// file: test/sidr_vco_model.sv
`timescale 1ns/1ps
// Oscillator stand-in for both band pins
module sidr_vco_model #(
	parameter real HALF_NS = 20.0
) (
	input  wire logic hpd_i,
	input  wire logic lpd_i,
	output wire logic hi_o,
	output wire logic lo_o
);
	logic osc = 1'h0;
	// Free-running tone
	always #(HALF_NS) osc = ~osc;
	// A pulled-down pin reads low
	assign hi_o = osc & ~hpd_i;
	assign lo_o = osc & ~lpd_i;
endmodule // sidr_vco_model

// file: test/sidr_top_chk.sv
`timescale 1ns/1ps
`include "sidr_regs.vh"
// Port checker
module sidr_top_chk (
	input wire logic        clk_sys_i,
	input wire logic        resetn_i,
	input wire logic [7:0]  periph_addr_i,
	input wire logic [15:0] staging_buffer_i,
	input wire logic        periph_put_i,
	input wire logic        periph_get_i,
	input wire logic [15:0] staging_buffer_o,
	input wire logic [1:0]  mode_select_i,
	input wire logic [3:0]  ref_select_i,
	input wire logic        high_band_pulldown_o,
	input wire logic        low_band_pulldown_o,
	input wire logic        divided_frequency_o,
	input wire logic        reference_frequency_o,
	input wire logic        error_out_float_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Decoded conditions
	wire off = mode_select_i == 2'h3 || ref_select_i == 4'hF;
	wire rd = periph_get_i && periph_addr_i == 8'h41;
	wire wr = periph_put_i && periph_addr_i == 8'h41;
	wire stop = ref_select_i inside {4'h9, 4'hA, 4'hB, 4'hF};
	// Last value written to the ratio register
	logic [15:0] shadow_q;
	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shadow_q <= `SIDR_DIV_RATIO_RESET;
		end else if (wr) begin
			shadow_q <= staging_buffer_i;
		end
	end
	a_low_band_pins: assert property (mode_select_i < 2'h2 && !off
		|-> high_band_pulldown_o && !low_band_pulldown_o) else $error("low band pins");
	a_high_band_pins: assert property (mode_select_i == 2'h2 && !off
		|-> low_band_pulldown_o && !high_band_pulldown_o) else $error("high band pins");
	a_both_pulled: assert property (off
		|-> low_band_pulldown_o && high_band_pulldown_o) else $error("pins not pulled");
	a_float_disable: assert property (
		error_out_float_o == (ref_select_i == 4'hF)) else $error("float flag");
	a_div_held: assert property (off [*2] |-> !divided_frequency_o) else $error("div pulse");
	a_ref_stops: assert property (stop [*2] |-> !reference_frequency_o) else $error("ref pulse");
	a_get_hold: assert property (!rd |=> $stable(staging_buffer_o)) else $error("read drift");
	a_put_get: assert property (rd
		|=> staging_buffer_o == $past(shadow_q)) else $error("read-back");
	c_div: cover property (divided_frequency_o && mode_select_i == 2'h2);
	c_ref: cover property (reference_frequency_o && mode_select_i == 2'h3);
	c_rd: cover property (rd);
endmodule // sidr_top_chk

// file: test/tb.sv
`timescale 1ns/1ps
`include "sidr_regs.vh"
module tb;
	logic        clk_sys_i = 1'h0, xtal_clk_i = 1'h0, resetn_i = 1'h0;
	logic        periph_put_i = 1'h0, periph_get_i = 1'h0;
	logic [7:0]  periph_addr_i = 8'h00;
	logic [15:0] staging_buffer_i = 16'h0000, d;
	logic [1:0]  mode_select_i = 2'h3;
	logic [3:0]  ref_select_i = 4'hF;
	wire  [15:0] staging_buffer_o;
	wire         high_band_osc_input_i, low_band_osc_input_i, high_band_pulldown_o, low_band_pulldown_o;
	wire         divided_frequency_o, reference_frequency_o, synth_disabled_o, error_out_float_o;
	int          n_mismatch = 0, checks = 0, n;
	logic [3:0]  rc [4] = '{4'hE, 4'h7, 4'h6, 4'h5};
	int          rv [4] = '{45, 90, 180, 360};
	// System and crystal clocks
	always #2.5 clk_sys_i = ~clk_sys_i;
	always #111.111 xtal_clk_i = ~xtal_clk_i;
	sidr_top DUT (.clk_sys_i, .resetn_i, .periph_addr_i, .staging_buffer_i, .periph_put_i, .periph_get_i,
		.staging_buffer_o, .mode_select_i, .ref_select_i, .high_band_osc_input_i, .low_band_osc_input_i,
		.xtal_clk_i, .high_band_pulldown_o, .low_band_pulldown_o, .divided_frequency_o,
		.reference_frequency_o, .synth_disabled_o, .error_out_float_o);
	sidr_vco_model u_vco (.hpd_i(high_band_pulldown_o), .lpd_i(low_band_pulldown_o),
		.hi_o(high_band_osc_input_i), .lo_o(low_band_osc_input_i));
	// One register bus cycle
	task automatic bus(input logic p, g, input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys_i); #1;
		{periph_put_i, periph_get_i, periph_addr_i, staging_buffer_i} = {p, g, a, v};
		@(posedge clk_sys_i); #1;
		{periph_put_i, periph_get_i} = 2'h0;
	endtask
	task automatic chk16(input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin n_mismatch++; $display("[ERR] %0t read %h exp %h", $time, got, exp); end
	endtask
	task automatic chkn(input int got, exp);
		checks++;
		if (got > exp + 2 || got < exp - 2) begin n_mismatch++; $display("[ERR] %0t gap %0d exp %0d", $time, got, exp); end
	endtask
	// Cycles between two output pulses
	task automatic gap(input bit w, output int k);
		repeat (2) begin
			k = 0;
			do begin @(posedge clk_sys_i); #1; k++; end
			while ((w ? reference_frequency_o : divided_frequency_o) !== 1'h1 && k < 40000);
		end
	endtask
	function automatic int exp_n(input logic [1:0] m, input logic [15:0] r);
		return m == 2'h0 ? r[15:4] : 16 * r[15:4] + r[3:0];
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(89577));
		repeat (3) @(posedge clk_sys_i);
		#1 resetn_i = 1'h1;
		bus(1'h0, 1'h1, 8'h41, 16'h0000);
		chk16(staging_buffer_o, `SIDR_DIV_RATIO_RESET);
		repeat (6) begin
			d = $urandom;
			bus(1'h1, 1'h0, 8'h41, d);
			bus(1'h1, 1'h1, 8'h40, ~d);
			bus(1'h0, 1'h1, 8'h41, 16'h0000);
			chk16(staging_buffer_o, d);
		end
		repeat (30) begin @(posedge clk_sys_i); #1; {mode_select_i, ref_select_i} = 6'($urandom); end
		$display("test regs done");
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 2; k++) begin
				d = k == 0 ? 16'h010F : {12'(16 + $urandom_range(m == 0 ? 280 : 4)), 4'($urandom)};
				{mode_select_i, ref_select_i} = 6'h3E;
				bus(1'h1, 1'h0, 8'h41, d);
				mode_select_i = 2'(m);
				gap(1'h0, n);
				chkn(n, 8 * exp_n(2'(m), d));
			end
		end
		$display("test divider done");
		mode_select_i = 2'h3;
		foreach (rc[i]) begin
			ref_select_i = rc[i];
			gap(1'h1, n);
			chkn(n, $rtoi(rv[i] * 44.4444 + 0.5));
		end
		for (int c = 9; c < 16; c += 2) begin ref_select_i = 4'(c); repeat (300) @(posedge clk_sys_i); #1; end
		$display("test reference done");
		finish_test();
	end
	// Watchdog
	initial begin
		#500000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end
endmodule // tb
bind sidr_top sidr_top_chk u_chk (.clk_sys_i, .resetn_i, .periph_addr_i, .staging_buffer_i, .periph_put_i,
	.periph_get_i, .staging_buffer_o, .mode_select_i, .ref_select_i, .high_band_pulldown_o,
	.low_band_pulldown_o, .divided_frequency_o, .reference_frequency_o, .error_out_float_o);
